// ### hw/isd_pkg.sv
/*
 * isd_pkg: constants and types for the interrupt status and remote DMA
 * register slice.
 * Assumes: 32-bit APB slave with one aligned word per register. The byte
 * address of each register is four times its index.
 */
package isd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indices, byte address = index * 4
    localparam int unsigned ISD_ADDR_W      = 8;
    localparam logic [5:0]  ISD_IDX_CMD     = 6'h00;
    localparam logic [5:0]  ISD_IDX_STATUS  = 6'h07;
    localparam logic [5:0]  ISD_IDX_ADDR_LO = 6'h08;
    localparam logic [5:0]  ISD_IDX_ADDR_HI = 6'h09;
    localparam logic [5:0]  ISD_IDX_LEN_LO  = 6'h0a;
    localparam logic [5:0]  ISD_IDX_LEN_HI  = 6'h0b;
    localparam logic [5:0]  ISD_IDX_TALLY   = 6'h0e;
    localparam logic [5:0]  ISD_IDX_MASK    = 6'h0f;

    ////////////////////////////////////////////////////////////////////////
    // interrupt status bit positions
    localparam int unsigned ISD_BIT_RST  = 7;
    localparam int unsigned ISD_BIT_DMA  = 6;
    localparam int unsigned ISD_BIT_OFL  = 5;
    localparam int unsigned ISD_BIT_RING = 4;
    localparam int unsigned ISD_BIT_TERR = 3;
    localparam int unsigned ISD_BIT_RERR = 2;
    localparam int unsigned ISD_BIT_TOK  = 1;
    localparam int unsigned ISD_BIT_ROK  = 0;

    // command register fields
    localparam int unsigned ISD_CMD_START = 1;
    localparam int unsigned ISD_CMD_RD_LO = 3;
    localparam int unsigned ISD_CMD_ABORT = 5;

    ////////////////////////////////////////////////////////////////////////
    // reset values and the crc tally saturation limit
    localparam logic [7:0]  ISD_STATUS_RST = 8'h80;
    localparam logic [7:0]  ISD_MASK_RST   = 8'h00;
    localparam logic [7:0]  ISD_TALLY_RST  = 8'h00;
    localparam logic [15:0] ISD_WORD_RST   = 16'h0000;
    localparam logic [7:0]  ISD_TALLY_MAX  = 8'hff;

    ////////////////////////////////////////////////////////////////////////
    // events from the MAC, receive ring and DMA engine, one-cycle pulses
    typedef struct packed {
        logic tx_ok;
        logic tx_excess_col;
        logic tx_oversize;
        logic tx_late_col;
        logic rx_ok;
        logic rx_crc_err;
        logic rx_align_err;
        logic rx_missed;
        logic rx_addr_match;
        logic ring_full;
        logic wake;
        logic dma_xfer;
        logic tally_msb;
        logic soft_reset;
    } isd_evt_t;

    typedef enum logic {
        ISD_DMA_IDLE,
        ISD_DMA_RUN
    } isd_dma_state_t;

endpackage : isd_pkg

// ### hw/isd_regs.sv
/*
 * isd_regs: interrupt status, remote DMA setup and current address
 * registers of an Ethernet controller host interface, as an APB slave.
 * Assumes: event inputs come from logic on pclk as one-cycle pulses; the
 * DMA engine pulses dma_xfer once per byte moved while dma_busy is high.
 */
// Operation
// - reset-status flag set on reset or wake; status reads 80h after reset
// - start command clears the reset-status flag
// - host writes to the status register never change the reset-status flag
// - remote-DMA-complete flag set when remote DMA finishes
// - counter-overflow flag set when a tally counter MSB becomes set while no MSB was set before
// - overwrite flag set when receive ring storage runs out
// - transmit-error flag on excess collisions, oversize or late collision
// - receive-error flag on CRC error, alignment error or missed frame
// - transmit-done flag when a frame is sent cleanly
// - receive-done flag when a frame is received cleanly
// - writing one clears that event flag, writing zero leaves it
// - start address loaded as low byte and high byte, in either order
// - byte count loaded as low byte and high byte
// - current DMA address readable as two bytes, reset 00h
// - offsets 08h/09h read current address, write start address
// - start bit stays set until hardware or software reset
// - CRC tally counts address-matched frames with CRC error
`timescale 1ns/1ps
module isd_regs
    import isd_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ISD_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire isd_evt_t              evt,
    output logic                       irq,
    output logic                       start_bit,
    output logic                       dma_busy,
    output logic      [15:0]           dma_addr
);

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, answer on the second access cycle
    logic [31:0]    prdata_reg, prdata_next;
    logic           pready_reg, pready_next;
    logic           pslverr_reg, pslverr_next;
    logic [5:0]     idx;
    logic           mapped;
    logic           wr_fire;
    logic           rd_fire;

    logic [7:0]     status_reg, status_next;
    logic [7:0]     mask_reg, mask_next;
    logic           irq_reg, irq_next;
    logic [7:0]     tally_reg, tally_next;
    logic           msb_prev_reg, msb_prev_next;
    logic           start_reg, start_next;
    logic [15:0]    saddr_reg, saddr_next;
    logic [15:0]    count_reg, count_next;
    logic [15:0]    curr_reg, curr_next;
    logic [15:0]    remain_reg, remain_next;
    logic           busy_reg, busy_next;
    isd_dma_state_t state_reg, state_next;
    logic           dma_done;
    logic [7:0]     ev_set;
    logic [7:0]     ev_clr;
    logic           msb_any;

    assign idx     = paddr[7:2];
    assign wr_fire = psel & penable & pready_reg & pwrite & pstrb[0];
    assign rd_fire = psel & penable & pready_reg & ~pwrite;

    always_comb begin
        case (idx)
            ISD_IDX_CMD, ISD_IDX_STATUS, ISD_IDX_ADDR_LO, ISD_IDX_ADDR_HI,
            ISD_IDX_LEN_LO, ISD_IDX_LEN_HI, ISD_IDX_TALLY,
            ISD_IDX_MASK: mapped = 1'b1;
            default:      mapped = 1'b0;
        endcase
    end

    always_comb begin
        pready_next  = psel & penable & ~pready_reg;
        pslverr_next = pready_next & ~mapped;
        prdata_next  = prdata_reg;
        if (pready_next && !pwrite) begin
            case (idx)
                ISD_IDX_CMD:     prdata_next = {30'h0, start_reg, 1'b0};
                ISD_IDX_STATUS:  prdata_next = {24'h0, status_reg};
                ISD_IDX_ADDR_LO:
                    prdata_next = {24'h0, curr_reg[7:0]};
                ISD_IDX_ADDR_HI:
                    prdata_next = {24'h0, curr_reg[15:8]};
                ISD_IDX_TALLY:   prdata_next = {24'h0, tally_reg};
                ISD_IDX_MASK:    prdata_next = {24'h0, mask_reg};
                default:         prdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command, setup registers and remote dma sequencing
    logic cmd_wr;
    logic dma_go;
    logic dma_abort;

    // any non-zero mode field starts unless the abort bit is set; direction is the engine's concern
    assign cmd_wr    = wr_fire & (idx == ISD_IDX_CMD);
    assign dma_abort = cmd_wr & pwdata[ISD_CMD_ABORT];
    assign dma_go    = cmd_wr & ~pwdata[ISD_CMD_ABORT]
                     & (pwdata[ISD_CMD_ABORT-1:ISD_CMD_RD_LO] != 2'b00);

    always_comb begin
        start_next  = start_reg;
        saddr_next  = saddr_reg;
        count_next  = count_reg;
        curr_next   = curr_reg;
        remain_next = remain_reg;
        state_next  = state_reg;
        dma_done    = 1'b0;
        if (cmd_wr && pwdata[ISD_CMD_START]) begin
            start_next = 1'b1;
        end
        if (wr_fire) begin
            case (idx)
                ISD_IDX_ADDR_LO:
                    saddr_next[7:0] = pwdata[7:0];
                ISD_IDX_ADDR_HI: saddr_next[15:8] = pwdata[7:0];
                ISD_IDX_LEN_LO:  count_next[7:0]  = pwdata[7:0];
                ISD_IDX_LEN_HI:  count_next[15:8] = pwdata[7:0];
                default:         ;
            endcase
        end
        case (state_reg)
            ISD_DMA_IDLE: begin
                // an abort while idle still reports completion
                if (dma_abort) begin
                    dma_done = 1'b1;
                end else if (dma_go) begin
                    curr_next   = saddr_reg;
                    remain_next = count_reg;
                    if (count_reg == ISD_WORD_RST) begin
                        dma_done = 1'b1;
                    end else begin
                        state_next = ISD_DMA_RUN;
                    end
                end
            end
            ISD_DMA_RUN: begin
                if (dma_abort) begin
                    dma_done   = 1'b1;
                    state_next = ISD_DMA_IDLE;
                end else if (evt.dma_xfer) begin
                    curr_next   = curr_reg + 16'h0001;
                    remain_next = remain_reg - 16'h0001;
                    if (remain_reg == 16'h0001) begin
                        dma_done   = 1'b1;
                        state_next = ISD_DMA_IDLE;
                    end
                end
            end
            default: state_next = ISD_DMA_IDLE;
        endcase
        if (evt.soft_reset) begin
            start_next = 1'b0;
            state_next = ISD_DMA_IDLE;
        end
        busy_next = (state_next == ISD_DMA_RUN);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_reg  <= 1'b0;
            saddr_reg  <= ISD_WORD_RST;
            count_reg  <= ISD_WORD_RST;
            curr_reg   <= ISD_WORD_RST;
            remain_reg <= ISD_WORD_RST;
            state_reg  <= ISD_DMA_IDLE;
            busy_reg   <= 1'b0;
        end else begin
            start_reg  <= start_next;
            saddr_reg  <= saddr_next;
            count_reg  <= count_next;
            curr_reg   <= curr_next;
            remain_reg <= remain_next;
            state_reg  <= state_next;
            busy_reg   <= busy_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event flags, crc tally, mask and interrupt line
    assign msb_any = tally_reg[7] | evt.tally_msb;

    always_comb begin
        ev_set = 8'h00;
        ev_set[ISD_BIT_RST] = evt.wake | evt.soft_reset;
        ev_set[ISD_BIT_DMA]  = dma_done;
        ev_set[ISD_BIT_OFL]  = msb_any & ~msb_prev_reg;
        ev_set[ISD_BIT_RING] = evt.ring_full;
        ev_set[ISD_BIT_TERR] = evt.tx_excess_col | evt.tx_oversize
                             | evt.tx_late_col;
        ev_set[ISD_BIT_RERR] = evt.rx_crc_err | evt.rx_align_err
                             | evt.rx_missed;
        ev_set[ISD_BIT_TOK]  = evt.tx_ok;
        ev_set[ISD_BIT_ROK]  = evt.rx_ok;
        ev_clr = 8'h00;
        if (wr_fire && idx == ISD_IDX_STATUS) begin
            ev_clr[6:0] = pwdata[6:0];
        end
        ev_clr[ISD_BIT_RST] = cmd_wr & pwdata[ISD_CMD_START];
        // a set in the same cycle as its clear wins
        status_next   = (status_reg & ~ev_clr) | ev_set;
        msb_prev_next = msb_any;
        tally_next    = tally_reg;
        if (rd_fire && idx == ISD_IDX_TALLY) begin
            // frames counted after the read value was captured are kept
            tally_next = tally_reg - prdata_reg[7:0];
        end
        if (evt.rx_crc_err && evt.rx_addr_match
            && tally_next != ISD_TALLY_MAX) begin
            tally_next = tally_next + 8'h01;
        end
        mask_next = mask_reg;
        if (wr_fire && idx == ISD_IDX_MASK) begin
            mask_next = pwdata[7:0];
        end
        irq_next = |(status_next & mask_next);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg   <= ISD_STATUS_RST;
            mask_reg     <= ISD_MASK_RST;
            tally_reg    <= ISD_TALLY_RST;
            msb_prev_reg <= 1'b0;
            irq_reg      <= 1'b0;
        end else begin
            status_reg   <= status_next;
            mask_reg     <= mask_next;
            tally_reg    <= tally_next;
            msb_prev_reg <= msb_prev_next;
            irq_reg      <= irq_next;
        end
    end

    assign prdata    = prdata_reg;
    assign pready    = pready_reg;
    assign pslverr   = pslverr_reg;
    assign irq       = irq_reg;
    assign start_bit = start_reg;
    assign dma_busy  = busy_reg;
    assign dma_addr  = curr_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic st_wr;
    assign st_wr = wr_fire & (idx == ISD_IDX_STATUS);

    rst_flag_set_a: assert property (evt.wake |=> status_reg[7])
        else $error("wake did not set reset flag");
    rst_flag_clr_a: assert property (
        cmd_wr && pwdata[1] && !evt.wake && !evt.soft_reset
        |=> !status_reg[7])
        else $error("start command did not clear reset flag");
    rst_flag_hold_a: assert property (
        status_reg[7] && !(cmd_wr && pwdata[1]) |=> status_reg[7])
        else $error("reset flag cleared without start command");
    dma_cmpl_a: assert property (
        busy_reg && evt.dma_xfer && remain_reg == 16'h0001
        |=> status_reg[6] && !busy_reg)
        else $error("dma completion flag missing");
    tally_ovf_a: assert property (
        $rose(tally_reg[7]) && !evt.tally_msb && !$past(evt.tally_msb)
        |=> status_reg[5])
        else $error("tally overflow not flagged");
    ring_full_a: assert property (evt.ring_full |=> status_reg[4])
        else $error("overwrite flag missing");
    tx_err_a: assert property (
        evt.tx_excess_col || evt.tx_oversize || evt.tx_late_col
        |=> status_reg[3])
        else $error("transmit error flag missing");
    rx_err_a: assert property (
        evt.rx_crc_err || evt.rx_align_err || evt.rx_missed
        |=> status_reg[2])
        else $error("receive error flag missing");
    tx_done_a: assert property (evt.tx_ok |=> status_reg[1])
        else $error("transmit done flag missing");
    rx_done_a: assert property (evt.rx_ok |=> status_reg[0])
        else $error("receive done flag missing");
    w1c_zero_a: assert property (
        st_wr && pwdata[6:0] == 7'h00
        |=> (status_reg[6:0] & $past(status_reg[6:0]))
            == $past(status_reg[6:0]))
        else $error("zero write changed a flag");
    w1c_one_a: assert property (
        st_wr && pwdata[0] && !evt.rx_ok |=> !status_reg[0])
        else $error("write one did not clear flag");
    start_load_a: assert property (
        wr_fire && idx == ISD_IDX_ADDR_HI
        |=> saddr_reg[15:8] == $past(pwdata[7:0]))
        else $error("start address high byte not loaded");
    count_load_a: assert property (
        wr_fire && idx == ISD_IDX_LEN_LO
        |=> count_reg[7:0] == $past(pwdata[7:0]))
        else $error("byte count low byte not loaded");
    curr_read_a: assert property (
        psel && penable && !pready_reg && !pwrite && idx == ISD_IDX_ADDR_LO
        |=> pready_reg && prdata_reg[7:0] == $past(curr_reg[7:0]))
        else $error("current address read wrong");
    start_stick_a: assert property (
        start_reg && !evt.soft_reset |=> start_reg)
        else $error("start bit dropped");
    tally_inc_a: assert property (
        evt.rx_crc_err && evt.rx_addr_match && tally_reg < 8'h7f && !rd_fire
        |=> tally_reg == $past(tally_reg) + 8'h01)
        else $error("crc tally did not count");
    dma_step_a: assert property (
        busy_reg && evt.dma_xfer && !dma_abort && remain_reg > 16'h0001
        && !evt.soft_reset |=> curr_reg == $past(curr_reg) + 16'h0001
        && remain_reg == $past(remain_reg) - 16'h0001)
        else $error("dma address did not advance");
    irq_level_a: assert property (
        |(status_reg & mask_reg) |-> irq_reg)
        else $error("interrupt not raised");
    host_wr_rst_a: assert property (
        st_wr && !status_reg[7] && !evt.wake && !evt.soft_reset
        |=> !status_reg[7])
        else $error("host write set reset flag");
    start_load_lo_a: assert property (
        wr_fire && idx == ISD_IDX_ADDR_LO
        |=> saddr_reg[7:0] == $past(pwdata[7:0]))
        else $error("start address low byte not loaded");
    count_load_hi_a: assert property (
        wr_fire && idx == ISD_IDX_LEN_HI
        |=> count_reg[15:8] == $past(pwdata[7:0]))
        else $error("byte count high byte not loaded");
    curr_read_hi_a: assert property (
        psel && penable && !pready_reg && !pwrite && idx == ISD_IDX_ADDR_HI
        |=> pready_reg && prdata_reg[7:0] == $past(curr_reg[15:8]))
        else $error("current address high byte read wrong");
    soft_stop_a: assert property (
        evt.soft_reset |=> !start_reg && !busy_reg)
        else $error("software reset did not stop");

    dma_full_c: cover property (dma_go ##[1:20] (busy_reg && dma_done));
    w1c_clear_c: cover property (st_wr && |(pwdata[6:0] & status_reg[6:0]));
    irq_rise_c: cover property ($rose(irq_reg));
    tally_ovf_c: cover property ($rose(status_reg[5]));
    dma_abort_c: cover property (busy_reg && dma_abort);

endmodule : isd_regs

// ### sim/isd_evt_model.sv
/*
 * isd_evt_model: far-side event source. It passes the bench's event
 * pulses through and acts as the DMA engine, moving one byte every
 * gap+1 cycles while dma_busy is high.
 * Assumes: ev_in and gap are driven on pclk; dma_busy comes from isd_regs.
 */
`timescale 1ns/1ps
module isd_evt_model
    import isd_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       dma_busy,
    input  wire logic [3:0] gap,
    input  wire isd_evt_t   ev_in,
    output isd_evt_t        evt
);
    logic [3:0] wait_reg;
    logic [3:0] wait_next;
    logic       xfer;

    // no byte is moved while the engine is idle
    always_comb begin
        xfer         = dma_busy && (wait_reg == gap);
        wait_next    = (!dma_busy || xfer) ? 4'h0 : wait_reg + 4'h1;
        evt          = ev_in;
        evt.dma_xfer = ev_in.dma_xfer | xfer;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 4'h0;
        end else begin
            wait_reg <= wait_next;
        end
    end
endmodule : isd_evt_model

// ### sim/tb_top.sv
/*
 * tb_top: self-checking bench for isd_regs, an APB master plus the
 * event and DMA model.
 * Assumes: one clock at 50 MHz; event cause bits sit at 13..6 and 4.
 */
`timescale 1ns/1ps
module tb_top
    import isd_pkg::*;
;
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [ISD_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
    logic [3:0]            pstrb;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  irq;
    logic                  start_bit;
    logic                  dma_busy;
    logic [15:0]           dma_addr;
    logic [3:0]            gap;
    isd_evt_t              ev_in;
    isd_evt_t              evt;
    isd_evt_t              e;
    logic [7:0]            exp_st;
    logic [7:0]            m;
    logic [7:0]            w;
    logic [15:0]           sa;
    logic [15:0]           n;
    logic [31:0]           r;
    logic                  err;
    int                    fail_count = 0;
    int                    total_checks = 0;
    int                    cycles = 0;
    int                    i;

    isd_regs isd_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .evt(evt), .irq(irq), .start_bit(start_bit), .dma_busy(dma_busy),
        .dma_addr(dma_addr));
    isd_evt_model isd_evt_model_i (.pclk(pclk), .presetn(presetn),
        .dma_busy(dma_busy), .gap(gap), .ev_in(ev_in), .evt(evt));

    always #10 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [5:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd,
                       output logic serr);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd   = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] rr;
        logic        ee;
        apb(1'b1, idx, d, rr, ee);
    endtask : wr

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        logic [31:0] rr;
        logic        ee;
        apb(1'b0, idx, 8'h00, rr, ee);
        chk(rr, {24'h0, exp});
    endtask : rd_chk

    task automatic pulse(input isd_evt_t pe);
        @(posedge pclk);
        ev_in <= pe;
        @(posedge pclk);
        ev_in <= '0;
    endtask : pulse

    // status bits that a cause pattern must set
    function automatic logic [7:0] flags_of(input isd_evt_t fe);
        logic [7:0] f;
        f    = 8'h00;
        f[0] = fe.rx_ok;
        f[1] = fe.tx_ok;
        f[2] = fe.rx_crc_err | fe.rx_align_err | fe.rx_missed;
        f[3] = fe.tx_excess_col | fe.tx_oversize | fe.tx_late_col;
        f[4] = fe.ring_full;
        return f;
    endfunction : flags_of

    task automatic dma_run(input logic [15:0] a, input logic [15:0] c);
        int k;
        wr(ISD_IDX_ADDR_LO, a[7:0]);
        wr(ISD_IDX_ADDR_HI, a[15:8]);
        wr(ISD_IDX_LEN_LO, c[7:0]);
        wr(ISD_IDX_LEN_HI, c[15:8]);
        // mode field 01, 10 or 11 together with the start bit
        wr(ISD_IDX_CMD, {3'h0, 2'($urandom_range(3, 1)), 3'h2});
        repeat (2) @(posedge pclk);
        k = 0;
        while (dma_busy === 1'b1 && k < 400) begin
            @(posedge pclk);
            k++;
        end
        a = a + c;
        chk({16'h0, dma_addr}, {16'h0, a});
        rd_chk(ISD_IDX_ADDR_LO, a[7:0]);
        rd_chk(ISD_IDX_ADDR_HI, a[15:8]);
        rd_chk(ISD_IDX_STATUS, 8'h40);
        wr(ISD_IDX_STATUS, 8'h40);
    endtask : dma_run

    ////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = '0; pwdata = '0; pstrb = 4'hf;
        ev_in = '0; gap = 4'h0;
        void'($urandom(50963));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ISD_IDX_STATUS, 8'h80);
        rd_chk(ISD_IDX_ADDR_LO, 8'h00);
        rd_chk(ISD_IDX_ADDR_HI, 8'h00);
        wr(ISD_IDX_STATUS, 8'hff);
        rd_chk(ISD_IDX_STATUS, 8'h80);
        wr(ISD_IDX_CMD, 8'h02);
        rd_chk(ISD_IDX_STATUS, 8'h00);
        chk({31'h0, start_bit}, 32'h1);
        // random causes, masks and write-one clears
        exp_st = 8'h00;
        for (i = 0; i < 24; i++) begin
            e = isd_evt_t'(14'($urandom) & 14'h3fd0);
            m = 8'($urandom);
            w = (i == 0) ? 8'h00 : 8'($urandom);
            wr(ISD_IDX_MASK, m);
            pulse(e);
            exp_st = exp_st | flags_of(e);
            rd_chk(ISD_IDX_STATUS, exp_st);
            wr(ISD_IDX_STATUS, w);
            exp_st = exp_st & ~w;
            rd_chk(ISD_IDX_STATUS, exp_st);
            chk({31'h0, irq}, {31'h0, |(exp_st & m)});
        end
        wr(ISD_IDX_STATUS, 8'h7f);
        // crc tally reaches its msb after 128 matched frames
        e = '0;
        e.rx_crc_err = 1'b1;
        e.rx_addr_match = 1'b1;
        @(posedge pclk);
        ev_in <= e;
        repeat (128) @(posedge pclk);
        ev_in <= '0;
        rd_chk(ISD_IDX_TALLY, 8'h80);
        rd_chk(ISD_IDX_TALLY, 8'h00);
        rd_chk(ISD_IDX_STATUS, 8'h24);
        wr(ISD_IDX_STATUS, 8'h24);
        e = '0;
        e.tally_msb = 1'b1;
        pulse(e);
        rd_chk(ISD_IDX_STATUS, 8'h20);
        wr(ISD_IDX_STATUS, 8'h20);
        // remote dma: zero count, address wrap, random runs
        for (i = 0; i < 5; i++) begin
            gap <= 4'($urandom_range(3, 0));
            sa = (i == 1) ? 16'hfffe : 16'($urandom);
            n  = (i == 0) ? 16'h0000 : 16'($urandom_range(6, 1));
            dma_run(sa, n);
        end
        gap <= 4'hf;
        wr(ISD_IDX_LEN_HI, 8'h01);
        wr(ISD_IDX_CMD, 8'h0a);
        wr(ISD_IDX_CMD, 8'h22);
        repeat (2) @(posedge pclk);
        chk({31'h0, dma_busy}, 32'h0);
        rd_chk(ISD_IDX_STATUS, 8'h40);
        wr(ISD_IDX_STATUS, 8'h40);
        rd_chk(ISD_IDX_LEN_LO, 8'h00);
        apb(1'b0, 6'h10, 8'h00, r, err);
        chk({31'h0, err}, 32'h1);
        // wake and software reset set the reset flag
        e = '0;
        e.wake = 1'b1;
        pulse(e);
        rd_chk(ISD_IDX_STATUS, 8'h80);
        wr(ISD_IDX_CMD, 8'h02);
        rd_chk(ISD_IDX_STATUS, 8'h00);
        e = '0;
        e.soft_reset = 1'b1;
        pulse(e);
        @(posedge pclk);
        chk({31'h0, start_bit}, 32'h0);
        rd_chk(ISD_IDX_STATUS, 8'h80);
        // second hardware reset with the dma engine idle
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ISD_IDX_STATUS, 8'h80);
        rd_chk(ISD_IDX_ADDR_LO, 8'h00);
        conclude();
    end
endmodule : tb_top
